// ===== pts_pkg.sv
package pts_pkg;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_TIMER     = 8'h04;
  localparam logic [7:0]  ADDR_APPLIED   = 8'h08;
  localparam logic [7:0]  ADDR_LAST_TX   = 8'h0c;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;

  localparam int          CTRL_RX_LSB    = 0;
  localparam int          CTRL_TX_LSB    = 8;
  localparam int          TIMER_EV_LSB   = 0;
  localparam int          TIMER_INH_LSB  = 16;
  localparam int          STAT_HOLD_BIT  = 16;
  localparam int          STAT_FULL_BIT  = 17;
  localparam int          STAT_INH_BIT   = 18;

  localparam logic [7:0]  TYPE_ACYCLIC   = 8'h00;
  localparam logic [7:0]  TYPE_CYC_MAX   = 8'hf0;
  localparam logic [7:0]  TYPE_ASYNC_A   = 8'hfe;
  localparam logic [7:0]  TYPE_ASYNC_B   = 8'hff;

  localparam logic [7:0]  RST_TYPE       = 8'hff;
  localparam logic [15:0] RST_TIME       = 16'h0000;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;

  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          MS_NS          = 1000000;
  localparam int          MS_CYCLES      = MS_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic [15:0] high_word;
    logic [15:0] low_word;
  } pts_param_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pts_apb_req_t;

  typedef enum logic [1:0] {
    TXC_NONE   = 2'b00,
    TXC_SYNC   = 2'b01,
    TXC_CYCLIC = 2'b10,
    TXC_ASYNC  = 2'b11
  } pts_class_t;

  function automatic pts_class_t pts_classify(input logic [7:0] kind);
    pts_class_t c;
    c = TXC_NONE;
    if (kind == TYPE_ACYCLIC) begin
      c = TXC_SYNC;
    end else if (kind <= TYPE_CYC_MAX) begin
      c = TXC_CYCLIC;
    end else if (kind == TYPE_ASYNC_A || kind == TYPE_ASYNC_B) begin
      c = TXC_ASYNC;
    end
    return c;
  endfunction : pts_classify

endpackage : pts_pkg

// ===== pts_node.sv
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
// Behaviour
// - Receive objects carry data from master to this node and transmit objects carry data from this node to the master.
// - With asynchronous types an object goes out on a change when the event time is zero and on event-timer expiry otherwise, not on a SYNC period.
// - With type 0 the master sends receive data only on change and the node applies it at the next SYNC.
// - With type 0 the node sends transmit data only when it changed and a SYNC arrived, valid at the master on receipt.
// - With type 1 to 240 receive data is applied by the node only at the next SYNC.
// - With type N the node sends transmit data every N SYNCs regardless of change.
// - With type 254 receive data is applied by the node on receipt.
// - With type 254 or 255 the node sends once per event period and then stays silent for the inhibit time.
// - With type 254 or 255 and event and inhibit times both zero the node sends transmit data at once on every change.
// - Fast-changing monitored values should use a synchronous type so the network is not flooded.
module pts_node #(
  parameter int MS_CYC = pts_pkg::MS_CYCLES
) (
  // Clock, reset and enable.
  input  wire logic                CLK,
  input  wire logic                NRST,
  input  wire logic                CE,
  // Register bus.
  input  wire pts_pkg::pts_apb_req_t APB_REQ,
  output logic [31:0]              PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // Objects from the master.
  input  wire logic                SYNC_RX,
  input  wire logic                RXPDO_VALID,
  input  wire pts_pkg::pts_param_t RXPDO_DATA,
  // Drive side.
  input  wire pts_pkg::pts_param_t MON_VALUE,
  output pts_pkg::pts_param_t      SPEED_CMD,
  output logic                     APPLY_STROBE,
  // Objects to the master.
  output logic                     TXPDO_VALID,
  output pts_pkg::pts_param_t      TXPDO_DATA,
  input  wire logic                TXPDO_READY
);
  import pts_pkg::*;

  logic [7:0]  rx_type_ff;
  logic [7:0]  tx_type_ff;
  logic [15:0] event_ms_ff;
  logic [15:0] inhibit_ms_ff;
  logic [15:0] tx_count_ff;
  logic [31:0] nxt_rdata;
  logic        nxt_err;
  logic        access;
  logic        commit;
  pts_class_t  rx_class;
  pts_class_t  tx_class;

  assign rx_class = pts_classify(rx_type_ff);
  assign tx_class = pts_classify(tx_type_ff);

  // Zero-wait decoding would make PREADY combinational, so one wait state
  // is spent to keep every bus output on a flip-flop.
  assign access = APB_REQ.psel & APB_REQ.penable;
  assign commit = access & PREADY;

  pts_param_t  hold_ff;
  logic        hold_v_ff;
  pts_param_t  last_tx_ff;
  logic        tail_v_ff;
  logic [15:0] inh_left_ff;

  always_comb begin
    nxt_rdata = RST_WORD;
    nxt_err   = 1'b0;
    unique case (APB_REQ.paddr)
      ADDR_CTRL: begin
        nxt_rdata[CTRL_RX_LSB +: 8] = rx_type_ff;
        nxt_rdata[CTRL_TX_LSB +: 8] = tx_type_ff;
      end
      ADDR_TIMER: begin
        nxt_rdata[TIMER_EV_LSB +: 16]  = event_ms_ff;
        nxt_rdata[TIMER_INH_LSB +: 16] = inhibit_ms_ff;
      end
      ADDR_APPLIED: nxt_rdata = SPEED_CMD;
      ADDR_LAST_TX: nxt_rdata = last_tx_ff;
      ADDR_STATUS: begin
        nxt_rdata[15:0]          = tx_count_ff;
        nxt_rdata[STAT_HOLD_BIT] = hold_v_ff;
        nxt_rdata[STAT_FULL_BIT] = tail_v_ff;
        nxt_rdata[STAT_INH_BIT]  = (inh_left_ff != RST_TIME);
      end
      default: nxt_err = 1'b1;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= RST_WORD;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= access & ~PREADY;
      if (access & ~PREADY) begin
        PRDATA  <= APB_REQ.pwrite ? RST_WORD : nxt_rdata;
        PSLVERR <= nxt_err;
      end else begin
        PRDATA  <= RST_WORD;
        PSLVERR <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_type_ff    <= RST_TYPE;
      tx_type_ff    <= RST_TYPE;
      event_ms_ff   <= RST_TIME;
      inhibit_ms_ff <= RST_TIME;
    end else if (CE && commit && APB_REQ.pwrite) begin
      if (APB_REQ.paddr == ADDR_CTRL) begin
        rx_type_ff <= APB_REQ.pwdata[CTRL_RX_LSB +: 8];
        tx_type_ff <= APB_REQ.pwdata[CTRL_TX_LSB +: 8];
      end
      if (APB_REQ.paddr == ADDR_TIMER) begin
        event_ms_ff   <= APB_REQ.pwdata[TIMER_EV_LSB +: 16];
        inhibit_ms_ff <= APB_REQ.pwdata[TIMER_INH_LSB +: 16];
      end
    end
  end

  // Receive path: received objects only ever flow into the drive.
  logic rx_now;
  assign rx_now = RXPDO_VALID & (rx_class == TXC_ASYNC);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold_ff      <= RST_WORD;
      hold_v_ff    <= 1'b0;
      SPEED_CMD    <= RST_WORD;
      APPLY_STROBE <= 1'b0;
    end else if (CE) begin
      APPLY_STROBE <= 1'b0;
      if (rx_now) begin
        SPEED_CMD    <= RXPDO_DATA;
        APPLY_STROBE <= 1'b1;
        hold_v_ff    <= 1'b0;
      end else if (SYNC_RX && hold_v_ff) begin
        SPEED_CMD    <= hold_ff;
        APPLY_STROBE <= 1'b1;
        hold_v_ff    <= 1'b0;
      end
      // A word arriving with a SYNC waits for the following SYNC.
      if (RXPDO_VALID && (rx_class == TXC_SYNC || rx_class == TXC_CYCLIC)) begin
        hold_ff   <= RXPDO_DATA;
        hold_v_ff <= 1'b1;
      end
    end
  end

  // Millisecond time base for the event and inhibit timers.
  logic [15:0] ms_cnt_ff;
  logic        ms_tick_ff;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ms_cnt_ff  <= RST_TIME;
      ms_tick_ff <= 1'b0;
    end else if (CE) begin
      ms_tick_ff <= (ms_cnt_ff == 16'(MS_CYC - 1));
      if (ms_cnt_ff == 16'(MS_CYC - 1)) begin
        ms_cnt_ff <= RST_TIME;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      end
    end
  end

  // Transmit scheduling.
  logic [7:0]  sync_cnt_ff;
  logic [15:0] ev_cnt_ff;
  logic        due_ff;
  logic        pend_ff;
  logic        changed;
  logic        inh_clear;
  logic        cyc_hit;
  logic        ev_hit;
  logic        trig;
  logic        push;

  assign changed   = (MON_VALUE != last_tx_ff);
  assign inh_clear = (inh_left_ff == RST_TIME);
  assign cyc_hit   = SYNC_RX & ((sync_cnt_ff + 8'h01) == tx_type_ff);
  assign ev_hit    = ms_tick_ff & (event_ms_ff != RST_TIME)
                   & ((ev_cnt_ff + 16'h0001) >= event_ms_ff);
  assign push      = pend_ff & ~tail_v_ff;

  always_comb begin
    trig = 1'b0;
    unique case (tx_class)
      TXC_NONE:   trig = 1'b0;
      TXC_SYNC:   trig = SYNC_RX & changed;
      TXC_CYCLIC: trig = cyc_hit;
      TXC_ASYNC: begin
        if (event_ms_ff != RST_TIME) begin
          trig = due_ff & inh_clear;
        end else begin
          trig = changed & inh_clear;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sync_cnt_ff <= 8'h00;
    end else if (CE && tx_class == TXC_CYCLIC && SYNC_RX) begin
      sync_cnt_ff <= cyc_hit ? 8'h00 : sync_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ev_cnt_ff <= RST_TIME;
      due_ff    <= 1'b0;
    end else if (CE) begin
      if (tx_class != TXC_ASYNC || event_ms_ff == RST_TIME) begin
        ev_cnt_ff <= RST_TIME;
        due_ff    <= 1'b0;
      end else begin
        if (ms_tick_ff) begin
          ev_cnt_ff <= ev_hit ? RST_TIME : ev_cnt_ff + 16'h0001;
        end
        // An expiry during the inhibit time is kept, not dropped.
        due_ff <= ev_hit | (due_ff & ~trig);
      end
    end
  end

  // A trigger landing while the buffer is full waits here.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pend_ff <= 1'b0;
    end else if (CE) begin
      pend_ff <= trig | (pend_ff & ~push);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      last_tx_ff  <= RST_WORD;
      tx_count_ff <= RST_TIME;
      inh_left_ff <= RST_TIME;
    end else if (CE) begin
      if (push) begin
        last_tx_ff  <= MON_VALUE;
        tx_count_ff <= tx_count_ff + 16'h0001;
      end
      if (push && tx_class == TXC_ASYNC) begin
        inh_left_ff <= inhibit_ms_ff;
      end else if (ms_tick_ff && !inh_clear) begin
        inh_left_ff <= inh_left_ff - 16'h0001;
      end
    end
  end

  // Two-entry buffer toward the master; the head drives the port directly.
  pts_param_t tail_ff;
  logic       pop;
  assign pop = TXPDO_VALID & TXPDO_READY;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TXPDO_VALID <= 1'b0;
      TXPDO_DATA  <= RST_WORD;
      tail_ff     <= RST_WORD;
      tail_v_ff   <= 1'b0;
    end else if (CE) begin
      if (pop) begin
        if (tail_v_ff) begin
          TXPDO_DATA <= tail_ff;
          tail_v_ff  <= 1'b0;
        end else if (push) begin
          TXPDO_DATA <= MON_VALUE;
        end else begin
          TXPDO_VALID <= 1'b0;
        end
      end else if (push) begin
        if (!TXPDO_VALID) begin
          TXPDO_DATA  <= MON_VALUE;
          TXPDO_VALID <= 1'b1;
        end else begin
          tail_ff   <= MON_VALUE;
          tail_v_ff <= 1'b1;
        end
      end
    end
  end

endmodule : pts_node

// ===== pts_master_mdl.sv
`timescale 1ns/10ps
module pts_master_mdl (
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                nrst,
  // Bench controls.
  input  wire logic [7:0]          per,
  input  wire logic                sync_go,
  input  wire logic                rx_go,
  input  wire pts_pkg::pts_param_t rx_word,
  input  wire logic                stall,
  // Node side.
  output logic                     sync_rx,
  output logic                     rxpdo_valid,
  output pts_pkg::pts_param_t      rxpdo_data,
  input  wire logic                txpdo_valid,
  input  wire pts_pkg::pts_param_t txpdo_data,
  output logic                     txpdo_ready,
  output logic [15:0]              got_cnt,
  output pts_pkg::pts_param_t      got_word
);
  import pts_pkg::*;
  logic [7:0] cnt_ff;
  assign txpdo_ready = !stall;
  // SYNC comes at a fixed period, or once on demand.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff  <= 8'h0;
      sync_rx <= 1'b0;
    end else begin
      cnt_ff  <= (cnt_ff + 8'h1 >= per) ? 8'h0 : cnt_ff + 8'h1;
      sync_rx <= sync_go | (per != 8'h0 && cnt_ff + 8'h1 >= per);
    end
  end
  // An idle data line toggles, so a stale word never looks valid.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxpdo_valid <= 1'b0;
      rxpdo_data  <= '0;
    end else begin
      rxpdo_valid <= rx_go;
      rxpdo_data  <= rx_go ? rx_word : ~rxpdo_data;
    end
  end
  // Transmit words count as valid on receipt.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      got_cnt  <= 16'h0;
      got_word <= '0;
    end else if (txpdo_valid && txpdo_ready) begin
      got_cnt  <= got_cnt + 16'h1;
      got_word <= txpdo_data;
    end
  end
endmodule : pts_master_mdl

// ===== pts_node_chk.sv
`timescale 1ns/10ps
module pts_node_chk #(
  parameter int MS_CYC = 10
) (
  input wire logic                  CLK,
  input wire logic                  NRST,
  input wire logic                  CE,
  input wire pts_pkg::pts_apb_req_t APB_REQ,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire logic                  SYNC_RX,
  input wire logic                  RXPDO_VALID,
  input wire pts_pkg::pts_param_t   RXPDO_DATA,
  input wire pts_pkg::pts_param_t   SPEED_CMD,
  input wire logic                  APPLY_STROBE,
  input wire logic                  TXPDO_VALID,
  input wire pts_pkg::pts_param_t   TXPDO_DATA,
  input wire logic                  TXPDO_READY
);
  import pts_pkg::*;
  logic [7:0] rx_type_ff;
  logic       acc;
  logic       mapped;
  assign acc = APB_REQ.psel && APB_REQ.penable;
  assign mapped = APB_REQ.paddr inside {ADDR_CTRL, ADDR_TIMER,
                  ADDR_APPLIED, ADDR_LAST_TX, ADDR_STATUS};
  // Shadow of the receive type, so timing checks follow the mode.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rx_type_ff <= RST_TYPE;
    end else if (CE && acc && PREADY && APB_REQ.pwrite
                 && APB_REQ.paddr == ADDR_CTRL) begin
      rx_type_ff <= APB_REQ.pwdata[7:0];
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_wait; acc && !PREADY; endsequence
  sequence s_stall; TXPDO_VALID && !TXPDO_READY; endsequence
  a_ready_one_wait:
    assert property (s_wait |=> PREADY) else $error("late ready");
  a_ready_pulse:
    assert property (PREADY |=> !PREADY) else $error("long ready");
  a_unmapped_err:
    assert property (PREADY |-> PSLVERR == !mapped && (mapped || PRDATA == 0))
    else $error("bad slave error");
  a_rx_async_apply:
    assert property (RXPDO_VALID && CE && rx_type_ff >= TYPE_ASYNC_A
      |=> APPLY_STROBE && SPEED_CMD == $past(RXPDO_DATA))
    else $error("word not applied");
  a_rx_sync_hold:
    assert property (RXPDO_VALID && !SYNC_RX && rx_type_ff <= TYPE_CYC_MAX
      |=> !APPLY_STROBE) else $error("applied before sync");
  a_strobe_cause:
    assert property (APPLY_STROBE |-> $past(SYNC_RX) || $past(RXPDO_VALID))
    else $error("strobe without cause");
  a_speed_stable:
    assert property (!APPLY_STROBE |-> $stable(SPEED_CMD))
    else $error("command moved");
  a_tx_hold:
    assert property (s_stall |=> TXPDO_VALID && $stable(TXPDO_DATA))
    else $error("offer dropped");
endmodule : pts_node_chk

bind pts_node pts_node_chk #(.MS_CYC(MS_CYC)) pts_node_chk_inst (
  .CLK(CLK), .NRST(NRST), .CE(CE), .APB_REQ(APB_REQ), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SYNC_RX(SYNC_RX),
  .RXPDO_VALID(RXPDO_VALID), .RXPDO_DATA(RXPDO_DATA),
  .SPEED_CMD(SPEED_CMD), .APPLY_STROBE(APPLY_STROBE),
  .TXPDO_VALID(TXPDO_VALID), .TXPDO_DATA(TXPDO_DATA),
  .TXPDO_READY(TXPDO_READY));

// ===== pts_node_tb_top.sv
`timescale 1ns/10ps
module pts_node_tb_top;
  import pts_pkg::*;
  typedef struct {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;
  } pts_row_t;
  logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, stall = 1'b0;
  logic sync_go = 1'b0, rx_go = 1'b0, sync_rx, rxv, apply, txv, txr;
  logic pready, e, pslverr;
  logic [31:0] prdata, r, want;
  logic [15:0] got_cnt, got0, cnt0;
  pts_apb_req_t req = '0;
  pts_param_t rx_word = '0, mon = '0, rxd, speed, txd, got_word;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  logic [7:0] styp [2] = '{8'h00, 8'h05};
  pts_row_t rows [11] = '{
    '{1'h0, ADDR_CTRL, 32'h0, 32'h0000ffff, 1'h0},
    '{1'h0, ADDR_TIMER, 32'h0, 32'h0, 1'h0},
    '{1'h1, ADDR_TIMER, 32'h00030002, 32'h0, 1'h0},
    '{1'h0, ADDR_TIMER, 32'h0, 32'h00030002, 1'h0},
    '{1'h1, ADDR_TIMER, 32'h0, 32'h0, 1'h0},
    '{1'h1, ADDR_APPLIED, 32'h1, 32'h0, 1'h0},
    '{1'h0, ADDR_APPLIED, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h14, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h20, 32'h5, 32'h0, 1'h1},
    '{1'h1, ADDR_CTRL, 32'h01fe, 32'h0, 1'h0},
    '{1'h0, ADDR_CTRL, 32'h0, 32'h01fe, 1'h0}};
  always #12.5 clk = ~clk;
  pts_node #(.MS_CYC(10)) pts_node_inst (.CLK(clk), .NRST(nrst), .CE(ce),
    .APB_REQ(req), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SYNC_RX(sync_rx), .RXPDO_VALID(rxv), .RXPDO_DATA(rxd),
    .MON_VALUE(mon), .SPEED_CMD(speed), .APPLY_STROBE(apply),
    .TXPDO_VALID(txv), .TXPDO_DATA(txd), .TXPDO_READY(txr));
  pts_master_mdl pts_master_mdl_inst (.clk(clk), .nrst(nrst), .per(8'h0),
    .sync_go(sync_go), .rx_go(rx_go), .rx_word(rx_word), .stall(stall),
    .sync_rx(sync_rx), .rxpdo_valid(rxv), .rxpdo_data(rxd),
    .txpdo_valid(txv), .txpdo_data(txd), .txpdo_ready(txr),
    .got_cnt(got_cnt), .got_word(got_word));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until ready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    req <= '0;
  endtask : apb
  task automatic sync1;
    @(posedge clk) sync_go <= 1'b1;
    @(posedge clk) sync_go <= 1'b0;
  endtask : sync1
  task automatic wstrobe;
    int t;
    t = 0;
    do begin @(posedge clk); t++; end while (apply !== 1'b1 && t < 60);
  endtask : wstrobe
  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(speed, 32'h0);
    chk(txv, 1'h0);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(r, rows[i].x);
      chk(e, rows[i].e);
    end
    @(posedge clk) {rx_go, rx_word} <= {1'b1, 32'h12345678};
    @(posedge clk) rx_go <= 1'b0;
    wstrobe;
    chk(speed, 32'h12345678);
    chk(speed.low_word, 32'h5678);
    want = 32'h12345678;
    foreach (styp[i]) begin
      apb(1'h1, ADDR_CTRL, {24'h1, styp[i]});
      @(posedge clk) {rx_go, rx_word} <= {1'b1, 24'hcafe00, styp[i]};
      @(posedge clk) rx_go <= 1'b0;
      repeat (6) @(posedge clk);
      chk(speed, want);
      sync1;
      wstrobe;
      want = {24'hcafe00, styp[i]};
      chk(speed, want);
    end
    apb(1'h1, ADDR_CTRL, 32'h03ff);
    mon <= 32'h0000abcd;
    stall <= 1'b1;
    apb(1'h0, ADDR_STATUS, 32'h0);
    cnt0 = r[15:0];
    repeat (6) sync1;
    repeat (4) @(posedge clk);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(r[15:0], cnt0 + 16'h2);
    chk(r[17], 1'h1);
    repeat (3) sync1;
    repeat (4) @(posedge clk);
    got0 = got_cnt;
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk(got_cnt, got0 + 16'h3);
    chk(got_word, 32'h0000abcd);
    apb(1'h1, ADDR_CTRL, 32'h00ff);
    sync1;
    // The SYNC reaches the node one edge after sync1 returns.
    @(posedge clk) mon <= 32'h00001111;
    repeat (6) @(posedge clk);
    chk(got_cnt, got0 + 16'h3);
    sync1;
    repeat (6) @(posedge clk);
    chk(got_word, 32'h00001111);
    apb(1'h1, ADDR_CTRL, 32'hffff);
    mon <= 32'h00002222;
    repeat (8) @(posedge clk);
    chk(got_word, 32'h00002222);
    apb(1'h1, ADDR_TIMER, 32'h00020000);
    mon <= 32'h00003333;
    repeat (6) @(posedge clk);
    chk(got_word, 32'h00003333);
    mon <= 32'h00004444;
    repeat (4) @(posedge clk);
    chk(got_word, 32'h00003333);
    apb(1'h0, ADDR_STATUS, 32'h0);
    chk(r[18], 1'h1);
    ce <= 1'b0;
    @(posedge clk) {rx_go, rx_word} <= {1'b1, 32'h0bad0bad};
    @(posedge clk) rx_go <= 1'b0;
    repeat (3) @(posedge clk);
    chk(speed, want);
    chk(apply, 1'h0);
    ce <= 1'b1;
    report_and_stop;
  end
endmodule : pts_node_tb_top
